// [rtl/safety_mode_watchdog.v]
// Safety mode watchdog: mode control, expiry actions and status
//
// Notes on behaviour
// R1: Locked safety entry accepted from pre-operational or reduced, taking action and period.
// R2: Locked safety mode is left only by power removal.
// R3: Expiry does nothing, resets the processor, or raises an interrupt.
// R4: Period codes select 0.25, 1, 4, 16, 64, 256, 1024 or 4096 ms.
// R5: Locked entry with bad action code answers bad argument; every period code is accepted.
// R6: Locked entry while locked answers already locked.
// R7: Reduced safety entry accepted from pre-operational mode.
// R8: Reduced entry refused: already reduced, or locked status when locked.
// R9: Boot firmware enters reduced mode and sets action none.
// R10: In locked mode period and action changes answer locked status.
// R11: In pre-operational mode changes answer enter-reduced-first status.
// R12: Reduced mode allows runtime changes; a status bit shows reduced mode.
// R13: Service reloads the countdown with the configured period.
// R14: With auto service and interrupts on, firmware services every 30 ms.
// R15: Firmware keeps auto service on after startup and during init and exit.
// R16: Interrupt enable gates only the interrupt output, not the pending flag.
// R17: Pending flag sets on interrupt action expiry until acknowledged.
// R18: Acknowledge clears only pending; countdown is untouched.
// R19: After acting, the countdown restarts from the configured period.
// R20: Active status true only for a real action and no debugger attached.
// R21: Countdown decrements at a fixed time base and expires at zero.
`timescale 1ns/1ps
`default_nettype none
`include "wdog_map.vh"
module safety_mode_watchdog #(
  parameter integer TICK_CYCLES = `TICK_CYCLES,
  parameter integer RESET_CYCLES = `CPU_RESET_CYCLES
)(
  // Clock and reset
  input wire clock,
  input wire reset_n,
  // Mode requests, one-cycle pulses
  input wire enter_locked_safety,
  input wire enter_reduced_safety,
  // Configuration requests, one-cycle pulses with argument
  input wire set_expiry_period,
  input wire set_expiry_action,
  input wire [2:0] period_code,
  input wire [1:0] action_code,
  // Service and interrupt control, one-cycle pulses
  input wire service_reload,
  input wire auto_service_on,
  input wire auto_service_off,
  input wire expiry_irq_enable,
  input wire expiry_irq_disable,
  input wire expiry_irq_acknowledge,
  // Board state
  input wire debugger_attached,
  // Request answer
  output reg request_done,
  output reg [2:0] request_status,
  // Status
  output wire reduced_safety_status,
  output wire watchdog_active_status,
  output reg expiry_irq_pending,
  output reg auto_service_enabled,
  output reg irq_enabled,
  output reg [1:0] mode,
  output reg [1:0] expiry_action,
  output reg [2:0] expiry_period,
  // Actions towards the processor
  output wire cpu_irq,
  output reg cpu_reset
);
  wire tick;
  wire expired;
  reg [14:0] period_ticks;
  reg [7:0] reset_count;
  // Countdown reload after an accepted configuration or locked entry
  reg mode_change_load;
  wire action_ok = (action_code == `ACT_NONE) || (action_code == `ACT_CPU_RESET) ||
    (action_code == `ACT_CPU_IRQ);
  wire any_set = set_expiry_period || set_expiry_action;
  wire config_ok = !(set_expiry_action && !action_ok);
  wire is_reduced = (mode == `MODE_REDUCED);
  wire is_locked = (mode == `MODE_LOCKED);
  wire is_pre_op = (mode == `MODE_PRE_OP);
  wire load_now = service_reload; // R13
  wire run = watchdog_active_status; // R21

  // Period code n gives 4^n quarter-millisecond units
  always @*
  begin
    period_ticks = 15'h0001 << {expiry_period, 1'b0}; // R4
  end

  assign reduced_safety_status = is_reduced; // R12
  assign watchdog_active_status = (expiry_action != `ACT_NONE) && !debugger_attached; // R20
  assign cpu_irq = expiry_irq_pending && irq_enabled; // R16

  tick_divider #(
    .DIVIDE(TICK_CYCLES)
  ) u_tick (
    .clock(clock),
    .reset_n(reset_n),
    .tick(tick)
  );

  expiry_counter u_count (
    .clock(clock),
    .reset_n(reset_n),
    .load(load_now || mode_change_load),
    .load_value(period_ticks),
    .run(run),
    .tick(tick),
    .expired(expired)
  );

  // Mode and configuration requests; one request per cycle, locked entry first
  always @(posedge clock)
  begin
    if (!reset_n)
    begin
      mode <= `MODE_PRE_OP;
      expiry_action <= `ACT_NONE;
      expiry_period <= 3'h7;
      request_done <= 1'b0;
      request_status <= `STAT_OK;
      mode_change_load <= 1'b0;
    end
    else
    begin
      request_done <= enter_locked_safety || enter_reduced_safety || any_set;
      mode_change_load <= 1'b0;
      if (enter_locked_safety)
      begin
        if (is_locked)
          request_status <= `STAT_LOCKED; // R6
        else if (!action_ok)
          request_status <= `STAT_BAD_ARG; // R5
        else
        begin
          mode <= `MODE_LOCKED; // R1
          expiry_action <= action_code;
          expiry_period <= period_code;
          mode_change_load <= 1'b1;
          request_status <= `STAT_OK;
        end
      end
      else if (enter_reduced_safety)
      begin
        if (is_locked)
          request_status <= `STAT_LOCKED; // R8
        else if (is_reduced)
          request_status <= `STAT_ALREADY_REDUCED; // R8
        else
        begin
          mode <= `MODE_REDUCED; // R7
          request_status <= `STAT_OK;
        end
      end
      else if (any_set)
      begin
        if (is_locked)
          request_status <= `STAT_LOCKED; // R10
        else if (is_pre_op)
          request_status <= `STAT_PRE_OP; // R11
        else if (!config_ok)
          request_status <= `STAT_BAD_ARG;
        else
        begin
          if (set_expiry_period)
            expiry_period <= period_code; // R12
          if (set_expiry_action)
            expiry_action <= action_code; // R12
          mode_change_load <= 1'b1;
          request_status <= `STAT_OK;
        end
      end
    end
  end

  // Interrupt flags and auto service bookkeeping
  always @(posedge clock)
  begin
    if (!reset_n)
    begin
      expiry_irq_pending <= 1'b0;
      irq_enabled <= 1'b0;
      auto_service_enabled <= 1'b1;
    end
    else
    begin
      if (expired && expiry_action == `ACT_CPU_IRQ)
        expiry_irq_pending <= 1'b1; // R17
      else if (expiry_irq_acknowledge)
        expiry_irq_pending <= 1'b0; // R18
      if (expiry_irq_enable)
        irq_enabled <= 1'b1;
      else if (expiry_irq_disable)
        irq_enabled <= 1'b0;
      if (auto_service_on)
        auto_service_enabled <= 1'b1;
      else if (auto_service_off)
        auto_service_enabled <= 1'b0;
    end
  end

  // Processor reset pulse of fixed length; a reset on its own does not leave locked mode
  always @(posedge clock)
  begin
    if (!reset_n)
    begin
      cpu_reset <= 1'b0;
      reset_count <= 8'h00;
    end
    else if (expired && expiry_action == `ACT_CPU_RESET)
    begin
      cpu_reset <= 1'b1; // R3
      reset_count <= RESET_CYCLES[7:0];
    end
    else if (reset_count > 8'h01)
      reset_count <= reset_count - 8'h01;
    else
    begin
      reset_count <= 8'h00;
      cpu_reset <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [rtl/wdog_map.vh]
// Constants for the safety mode watchdog
`ifndef WDOG_MAP_VH
`define WDOG_MAP_VH
`define MODE_PRE_OP 2'h0
`define MODE_REDUCED 2'h1
`define MODE_LOCKED 2'h2
`define ACT_NONE 2'h0
`define ACT_CPU_RESET 2'h1
`define ACT_CPU_IRQ 2'h2
`define STAT_OK 3'h0
`define STAT_LOCKED 3'h1
`define STAT_PRE_OP 3'h2
`define STAT_ALREADY_REDUCED 3'h3
`define STAT_BAD_ARG 3'h4
`define CLOCK_HZ 50000000
`define TICK_US 250
`define TICK_CYCLES ((`CLOCK_HZ / 1000000) * `TICK_US)
`define CPU_RESET_CYCLES 16
`endif

// [rtl/tick_divider.v]
// Free running divider giving one pulse per watchdog time base unit
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter integer DIVIDE = 12500
)(
  // Clock and reset
  input wire clock,
  input wire reset_n,
  // Tick out
  output reg tick
);
  reg [23:0] count;

  always @(posedge clock)
  begin
    if (!reset_n)
    begin
      count <= 24'h000000;
      tick <= 1'b0;
    end
    else if (count == DIVIDE[23:0] - 24'h000001)
    begin
      count <= 24'h000000;
      tick <= 1'b1;
    end
    else
    begin
      count <= count + 24'h000001;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [rtl/expiry_counter.v]
// Loadable countdown in time base units, flags expiry at zero
`timescale 1ns/1ps
`default_nettype none
module expiry_counter (
  // Clock and reset
  input wire clock,
  input wire reset_n,
  // Control
  input wire load,
  input wire [14:0] load_value,
  input wire run,
  input wire tick,
  // Result
  output wire expired
);
  reg [14:0] count;
  assign expired = run && tick && (count == 15'h0001);

  always @(posedge clock)
  begin
    if (!reset_n)
      count <= 15'h0001;
    else if (load || expired)
      count <= load_value; // R19
    else if (run && tick)
      count <= count - 15'h0001; // R21
  end
endmodule
`default_nettype wire

// [sim/wdog_assertions.sv]
// Port level checks for the safety mode watchdog
`timescale 1ns/1ps
`default_nettype none
module wdog_assertions (
  // Clock and reset
  input wire clock,
  input wire reset_n,
  // Requests
  input wire enter_locked_safety,
  input wire enter_reduced_safety,
  input wire set_expiry_period,
  input wire set_expiry_action,
  input wire [2:0] period_code,
  input wire [1:0] action_code,
  input wire debugger_attached,
  // Watched outputs
  input wire request_done,
  input wire [2:0] request_status,
  input wire reduced_safety_status,
  input wire watchdog_active_status,
  input wire expiry_irq_pending,
  input wire irq_enabled,
  input wire [1:0] mode,
  input wire [1:0] expiry_action,
  input wire [2:0] expiry_period,
  input wire cpu_irq
);
  wire any_set = set_expiry_period | set_expiry_action;
  wire any_req = enter_locked_safety | enter_reduced_safety | any_set;
  wire set_only = any_set & ~enter_locked_safety & ~enter_reduced_safety;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_req_answered: assert property (any_req |=> request_done)
    else $error("request without answer");
  a_locked_kept: assert property (mode == 2'h2 |=> mode == 2'h2)
    else $error("locked mode left");
  a_locked_frozen: assert property (mode == 2'h2 |=> $stable(expiry_action) && $stable(expiry_period))
    else $error("locked settings changed");
  a_preop_refuse: assert property (mode == 2'h0 && set_only |=> request_status == 3'h2)
    else $error("pre-operational change not refused");
  a_reduced_flag: assert property (reduced_safety_status == (mode == 2'h1))
    else $error("reduced status wrong");
  a_active_flag: assert property (watchdog_active_status == (expiry_action != 2'h0 && !debugger_attached))
    else $error("active status wrong");
  a_irq_gate: assert property (cpu_irq == (expiry_irq_pending && irq_enabled))
    else $error("interrupt gating wrong");
  a_lock_entry: assert property (enter_locked_safety && mode != 2'h2 && action_code != 2'h3
    |=> mode == 2'h2 && expiry_action == $past(action_code) && expiry_period == $past(period_code))
    else $error("locked entry not applied");
  a_lock_reject: assert property (enter_locked_safety && (mode == 2'h2 || action_code == 2'h3)
    |=> request_status == ($past(mode) == 2'h2 ? 3'h1 : 3'h4))
    else $error("locked entry refusal wrong");
endmodule
`default_nettype wire

// [sim/firmware_model.sv]
// Processor firmware side: periodic service while auto service and interrupts are on
`timescale 1ns/1ps
`default_nettype none
module firmware_model #(
  // 30 ms at four clocks per 0.25 ms tick
  parameter int SERVICE_CYCLES = 480
)(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Status seen by firmware
  input wire logic auto_service_enabled,
  input wire logic irq_enabled,
  // Service request
  output logic service = 1'b0
);
  int count = 0;
  always @(negedge clock)
  begin
    service <= 1'b0;
    if (!reset_n || !(auto_service_enabled && irq_enabled))
      count <= 0;
    else if (count == SERVICE_CYCLES - 1)
    begin
      count <= 0;
      service <= 1'b1;
    end
    else
      count <= count + 1;
  end
endmodule
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench for the safety mode watchdog
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock = 0, reset_n = 0, debugger_attached = 0, svc = 0;
  logic enter_locked_safety = 0, enter_reduced_safety = 0, set_expiry_period = 0;
  logic set_expiry_action = 0, auto_service_on = 0, auto_service_off = 0;
  logic expiry_irq_enable = 0, expiry_irq_disable = 0, expiry_irq_acknowledge = 0;
  logic [2:0] period_code = 3'h0;
  logic [1:0] action_code = 2'h0;
  wire request_done, reduced_safety_status, watchdog_active_status, expiry_irq_pending;
  wire auto_service_enabled, irq_enabled, cpu_irq, cpu_reset, fw_svc, service_reload;
  wire [2:0] request_status, expiry_period;
  wire [1:0] mode, expiry_action;
  int err_count = 0, n_compared = 0, seed = 21, m = 0, act = 0, per = 7, st, i;
  assign service_reload = svc | fw_svc;
  always #10 clock = ~clock;
  safety_mode_watchdog #(.TICK_CYCLES(4)) u_safety_mode_watchdog (.*);
  firmware_model u_firmware_model (.clock, .reset_n, .auto_service_enabled, .irq_enabled,
    .service(fw_svc));
  task chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task results;
    $display("errors %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task tmo(input int n);
    if (n >= 100)
    begin
      err_count++;
      results();
    end
  endtask
  task pulse(input logic [5:0] b);
    @(negedge clock);
    {svc, auto_service_on, auto_service_off, expiry_irq_enable, expiry_irq_disable,
      expiry_irq_acknowledge} = b;
    @(negedge clock);
    {svc, auto_service_on, auto_service_off, expiry_irq_enable, expiry_irq_disable,
      expiry_irq_acknowledge} = 6'h00;
    #1;
  endtask
  // k is {locked entry, reduced entry, set period, set action}
  task req(input logic [3:0] k, input logic [1:0] a, input logic [2:0] p);
    @(negedge clock);
    {enter_locked_safety, enter_reduced_safety, set_expiry_period, set_expiry_action} = k;
    action_code = a;
    period_code = p;
    if (k[3])
      st = m == 2 ? 1 : a == 2'h3 ? 4 : 0;
    else if (k[2])
      st = m == 0 ? 0 : m == 1 ? 3 : 1;
    else
      st = m == 2 ? 1 : m == 0 ? 2 : k[0] && a == 2'h3 ? 4 : 0;
    if (st == 0)
    begin
      if (k[3] | k[2])
        m = k[3] ? 2 : 1;
      if (k[3] | k[0])
        act = a;
      if (k[3] | k[1])
        per = p;
    end
    @(negedge clock);
    chk(request_done, 1);
    chk(request_status, 16'(st));
    chk(mode, 16'(m));
    chk({expiry_action, expiry_period}, 16'({act[1:0], per[2:0]}));
    {enter_locked_safety, enter_reduced_safety, set_expiry_period, set_expiry_action} = 4'h0;
  endtask
  initial
  begin
    repeat (3) @(posedge clock);
    @(negedge clock) reset_n = 1;
    #1 chk({mode, expiry_action, expiry_period, auto_service_enabled}, 16'h0F);
    req(4'h2, 2'h0, 3'h1);
    req(4'h1, 2'h1, 3'h0);
    req(4'h4, 2'h0, 3'h0);
    req(4'h4, 2'h0, 3'h0);
    req(4'h1, 2'h3, 3'h0);
    req(4'h1, 2'h0, 3'h0);
    for (i = 0; i < 6; i++) req(4'h2, 2'h0, 3'($random(seed)));
    req(4'h3, 2'h2, 3'h1);
    @(negedge clock) debugger_attached = 1;
    #1 chk(watchdog_active_status, 0);
    debugger_attached = 0;
    #1 chk(watchdog_active_status, 1);
    pulse(6'h08);
    chk(auto_service_enabled, 0);
    pulse(6'h10);
    chk(auto_service_enabled, 1);
    for (i = 0; i < 100 && expiry_irq_pending !== 1'b1; i++) @(negedge clock);
    tmo(i);
    chk(cpu_irq, 0);
    pulse(6'h04);
    chk(cpu_irq, 1);
    pulse(6'h01);
    chk(expiry_irq_pending, 0);
    // Servicing faster than one period must hold off expiry
    for (i = 0; i < 8; i++) pulse(6'h20);
    chk(expiry_irq_pending, 0);
    for (i = 0; i < 100 && expiry_irq_pending !== 1'b1; i++) @(negedge clock);
    tmo(i);
    pulse(6'h02);
    chk({cpu_irq, expiry_irq_pending}, 16'h1);
    // No service after the acknowledge: only the automatic restart can raise pending again
    pulse(6'h01);
    chk(expiry_irq_pending, 0);
    for (i = 0; i < 100 && expiry_irq_pending !== 1'b1; i++) @(negedge clock);
    tmo(i);
    chk(expiry_irq_pending, 1);
    req(4'h8, 2'h3, 3'h2);
    req(4'h8, 2'h1, 3'h0);
    for (i = 0; i < 100 && cpu_reset !== 1'b1; i++) @(negedge clock);
    tmo(i);
    chk(cpu_reset, 1);
    req(4'h3, 2'h0, 3'h4);
    req(4'h4, 2'h0, 3'h0);
    req(4'h8, 2'h2, 3'h3);
    @(negedge clock) reset_n = 0;
    @(negedge clock) reset_n = 1;
    #1 chk(mode, 0);
    results();
  end
endmodule
bind safety_mode_watchdog wdog_assertions u_wdog_assertions (.*);
`default_nettype wire
